// >>> mtc_trigger_ctrl.sv
// Purpose: trigger, retrigger, settling and save/recall control
// Assumes: commands arrive as one-cycle pulses already decoded
// Notes: measurement engines report done and valid per measurement
`timescale 1ns/100ps
`include "mtc_regs.svh"
module mtc_trigger_ctrl #(
	parameter int MEAS = `MTC_MEAS_COUNT,
	parameter int SW = `MTC_STATE_WIDTH,
	parameter int SETTLE_CYCLES = `MTC_SETTLE_CYCLES
) (
	// clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	// trigger sources and abort
	input wire logic GET_IN,
	input wire logic TRG_CMD_IN,
	input wire logic IMMEDIATE_TRIGGER_CMD_IN,
	input wire logic ABORT_IN,
	// mode commands
	input wire logic SET_RETRIG_IN,
	input wire logic RETRIG_REP_IN,
	input wire logic SET_SETTLE_IN,
	input wire logic SETTLE_FULL_IN,
	input wire logic PRESET_IN,
	input wire logic GO_LOCAL_IN,
	input wire logic COMMON_RESET_IN,
	input wire logic GO_REMOTE_IN,
	// measurement activity
	input wire logic [MEAS-1:0] ON_SCREEN_IN,
	input wire logic [MEAS-1:0] STATE_ON_IN,
	input wire logic [MEAS-1:0] MEAS_DONE_IN,
	input wire logic [MEAS-1:0] MEAS_VALID_IN,
	// result query
	input wire logic QUERY_IN,
	// save and recall
	input wire logic SAVE_IN,
	input wire logic RECALL_IN,
	input wire logic [7:0] FILE_NUM_IN,
	input wire logic [SW-1:0] STATE_IN,
	// common commands
	input wire logic COMMON_CMD_IN,
	// outputs
	output logic [MEAS-1:0] ARM_OUT,
	output logic [MEAS-1:0] START_OUT,
	output logic [MEAS-1:0] HELD_OUT,
	output logic HOLDOFF_OUT,
	output logic RETRIG_REP_OUT,
	output logic SETTLE_FULL_OUT,
	output logic [SW-1:0] RESTORE_STATE_OUT,
	output logic RESTORE_VALID_OUT,
	output logic FILE_REJECT_OUT,
	output logic COMMON_ACK_OUT
);
	mtc_pkg::mtc_cycle_type cycle;
	mtc_pkg::mtc_cycle_type next_cycle;
	logic trigger;
	logic [MEAS-1:0] active;
	logic [MEAS-1:0] members;
	logic [MEAS-1:0] got_valid;
	logic all_valid;
	logic [31:0] settle_cnt;
	logic file_ok;
	logic recall_wait;
	logic remote_set;
	logic mode_default;
	logic [SW-1:0] mem_rdata;

	assign trigger = GET_IN | TRG_CMD_IN | IMMEDIATE_TRIGGER_CMD_IN;
	assign active = ON_SCREEN_IN & STATE_ON_IN;
	assign all_valid = ((got_valid | (MEAS_DONE_IN & MEAS_VALID_IN)) & members) == members;
	assign file_ok = FILE_NUM_IN <= `MTC_FILE_MAX;
	// remote with no prior remote setting falls to the defaults
	assign mode_default = PRESET_IN | GO_LOCAL_IN | COMMON_RESET_IN | (GO_REMOTE_IN & ~remote_set);

	always_comb begin
		next_cycle = cycle;
		unique case (cycle)
			mtc_pkg::MTC_IDLE, mtc_pkg::MTC_HOLD: begin
				if (trigger) begin
					next_cycle = SETTLE_FULL_OUT ? mtc_pkg::MTC_SETTLE : mtc_pkg::MTC_MEASURE;
				end
			end
			mtc_pkg::MTC_SETTLE: begin
				if (settle_cnt == 32'h0) begin
					next_cycle = mtc_pkg::MTC_MEASURE;
				end
			end
			mtc_pkg::MTC_MEASURE: begin
				// without valid results the cycle keeps retrying
				if (all_valid) begin
					next_cycle = RETRIG_REP_OUT ? mtc_pkg::MTC_MEASURE : mtc_pkg::MTC_HOLD;
				end
			end
			default: next_cycle = mtc_pkg::MTC_IDLE;
		endcase
		if (ABORT_IN) begin
			next_cycle = mtc_pkg::MTC_IDLE;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cycle <= mtc_pkg::MTC_IDLE;
		end else begin
			cycle <= next_cycle;
		end
	end

	// trigger mode
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RETRIG_REP_OUT <= `MTC_RETRIG_REP_RST;
			SETTLE_FULL_OUT <= `MTC_SETTLE_FULL_RST;
			remote_set <= 1'b0;
		end else if (mode_default) begin
			RETRIG_REP_OUT <= `MTC_RETRIG_REP_RST;
			SETTLE_FULL_OUT <= `MTC_SETTLE_FULL_RST;
			// a set that loses to a default still counts as a remote setting
			remote_set <= remote_set | SET_RETRIG_IN | SET_SETTLE_IN;
		end else begin
			if (SET_RETRIG_IN) begin
				RETRIG_REP_OUT <= RETRIG_REP_IN;
				remote_set <= 1'b1;
			end
			if (SET_SETTLE_IN) begin
				SETTLE_FULL_OUT <= SETTLE_FULL_IN;
				remote_set <= 1'b1;
			end
		end
	end

	// settle counter, loaded on the trigger
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			settle_cnt <= 32'h0;
		end else if (trigger && next_cycle != cycle && next_cycle == mtc_pkg::MTC_SETTLE) begin
			// triggers while settling are refused and must not restart the delay
			settle_cnt <= 32'(SETTLE_CYCLES - 1);
		end else if (cycle == mtc_pkg::MTC_SETTLE && settle_cnt != 32'h0) begin
			settle_cnt <= settle_cnt - 32'h1;
		end
	end

	// cycle membership and valid tracking
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			members <= '0;
			got_valid <= '0;
		end else if (trigger && (cycle == mtc_pkg::MTC_IDLE || cycle == mtc_pkg::MTC_HOLD)) begin
			members <= active;
			got_valid <= '0;
		end else if (cycle == mtc_pkg::MTC_MEASURE) begin
			if (all_valid) begin
				got_valid <= '0;
			end else begin
				got_valid <= got_valid | (MEAS_DONE_IN & MEAS_VALID_IN & members);
			end
		end
	end

	// arm and start for the measurement engines
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ARM_OUT <= '0;
			START_OUT <= '0;
			HELD_OUT <= '0;
		end else begin
			START_OUT <= '0;
			if (ABORT_IN) begin
				ARM_OUT <= '0;
				HELD_OUT <= '0;
			end else if (cycle != mtc_pkg::MTC_MEASURE && next_cycle == mtc_pkg::MTC_MEASURE) begin
				START_OUT <= (cycle == mtc_pkg::MTC_SETTLE) ? members : active;
				ARM_OUT <= (cycle == mtc_pkg::MTC_SETTLE) ? members : active;
				HELD_OUT <= '0;
			end else if (cycle == mtc_pkg::MTC_MEASURE && all_valid) begin
				if (RETRIG_REP_OUT) begin
					START_OUT <= members;
					ARM_OUT <= members;
				end else begin
					ARM_OUT <= '0;
					HELD_OUT <= members;
				end
			end else if (cycle == mtc_pkg::MTC_MEASURE) begin
				// retry any that finished without a valid result
				START_OUT <= MEAS_DONE_IN & ~MEAS_VALID_IN & members;
			end
		end
	end

	// holdoff while a queried result is not yet available
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			HOLDOFF_OUT <= 1'b0;
		end else if (ABORT_IN || next_cycle == mtc_pkg::MTC_HOLD) begin
			HOLDOFF_OUT <= 1'b0;
		end else if (QUERY_IN && cycle != mtc_pkg::MTC_HOLD && cycle != mtc_pkg::MTC_IDLE) begin
			HOLDOFF_OUT <= 1'b1;
		end else if (cycle == mtc_pkg::MTC_MEASURE && all_valid) begin
			HOLDOFF_OUT <= 1'b0;
		end
	end

	mtc_state_mem #(
		.WIDTH(SW),
		.DEPTH(`MTC_FILE_DEPTH)
	) u_mem (
		.clk_in(CLK_SYS_IN),
		.wr_in(SAVE_IN & file_ok),
		.addr_in(FILE_NUM_IN[6:0]),
		.wdata_in(STATE_IN),
		.rdata_out(mem_rdata)
	);

	// recall path and command acknowledges
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			recall_wait <= 1'b0;
			RESTORE_VALID_OUT <= 1'b0;
			RESTORE_STATE_OUT <= '0;
			FILE_REJECT_OUT <= 1'b0;
			COMMON_ACK_OUT <= 1'b0;
		end else begin
			recall_wait <= RECALL_IN & file_ok;
			RESTORE_VALID_OUT <= recall_wait;
			if (recall_wait) begin
				RESTORE_STATE_OUT <= mem_rdata;
			end
			FILE_REJECT_OUT <= (SAVE_IN | RECALL_IN) & ~file_ok;
			COMMON_ACK_OUT <= COMMON_CMD_IN;
		end
	end

	a_fast_direct: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_IDLE && trigger && !ABORT_IN && !SETTLE_FULL_OUT)
		|=> cycle == mtc_pkg::MTC_MEASURE) else $error("fast settle did not measure");
	a_full_settle: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_IDLE && trigger && !ABORT_IN && SETTLE_FULL_OUT)
		|=> cycle == mtc_pkg::MTC_SETTLE) else $error("full settle skipped");
	a_abort_idle: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		ABORT_IN |=> cycle == mtc_pkg::MTC_IDLE) else $error("abort ignored");
	a_single_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_MEASURE && all_valid && !RETRIG_REP_OUT && !ABORT_IN)
		|=> cycle == mtc_pkg::MTC_HOLD && ARM_OUT == '0) else $error("single no hold");
	a_hold_stays: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_HOLD && !trigger && !ABORT_IN)
		|=> cycle == mtc_pkg::MTC_HOLD && $stable(HELD_OUT)) else $error("hold lost");
	a_rep_restart: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_MEASURE && all_valid && RETRIG_REP_OUT && !ABORT_IN)
		|=> START_OUT == members && ARM_OUT == members) else $error("no restart");
	a_retry_stay: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_MEASURE && !all_valid && !ABORT_IN)
		|=> cycle == mtc_pkg::MTC_MEASURE) else $error("left without valid");
	a_mode_default: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		mode_default |=> RETRIG_REP_OUT && SETTLE_FULL_OUT) else $error("defaults not set");
	a_file_range: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		((SAVE_IN || RECALL_IN) && FILE_NUM_IN > 8'h63)
		|=> FILE_REJECT_OUT ##1 !RESTORE_VALID_OUT) else $error("bad file taken");
	a_recall_lat: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(RECALL_IN && file_ok) |=> ##1 RESTORE_VALID_OUT) else $error("recall late");
	a_settle_len: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_SETTLE && settle_cnt != 32'h0 && !ABORT_IN)
		|=> cycle == mtc_pkg::MTC_SETTLE) else $error("settle cut short");
	a_trig_start: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		((cycle == mtc_pkg::MTC_IDLE || cycle == mtc_pkg::MTC_HOLD) && trigger && !ABORT_IN
		&& !SETTLE_FULL_OUT) |=> START_OUT == $past(active)) else $error("start set wrong");
	a_settle_exit: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_SETTLE && settle_cnt == 32'h0 && !ABORT_IN)
		|=> cycle == mtc_pkg::MTC_MEASURE && START_OUT == members) else $error("settle stuck");
	a_hold_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(cycle == mtc_pkg::MTC_HOLD && !trigger && !ABORT_IN)
		|=> START_OUT == '0) else $error("restart while held");
	a_holdoff_set: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(QUERY_IN && !ABORT_IN && next_cycle != mtc_pkg::MTC_HOLD && cycle != mtc_pkg::MTC_IDLE
		&& cycle != mtc_pkg::MTC_HOLD) |=> HOLDOFF_OUT) else $error("no holdoff");
	a_holdoff_keep: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(HOLDOFF_OUT && cycle == mtc_pkg::MTC_MEASURE && !all_valid && !ABORT_IN)
		|=> HOLDOFF_OUT) else $error("holdoff dropped early");
	a_abort_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		ABORT_IN |=> ARM_OUT == '0 && HELD_OUT == '0 && !HOLDOFF_OUT)
		else $error("abort left state");
	a_common_ack: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		COMMON_CMD_IN |=> COMMON_ACK_OUT) else $error("common not acknowledged");
endmodule // mtc_trigger_ctrl

// >>> mtc_regs.svh
// Purpose: constants for the measurement trigger control block
// Assumes: one 200 MHz clock
// Notes: settle time kept in ns, cycles derived from the clock rate
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH
`define MTC_CLK_PERIOD_NS 5
`define MTC_SETTLE_TIME_NS 10000
`define MTC_SETTLE_CYCLES ((`MTC_SETTLE_TIME_NS + `MTC_CLK_PERIOD_NS - 1) / `MTC_CLK_PERIOD_NS)
`define MTC_FILE_MAX 8'h63
`define MTC_RETRIG_REP_RST 1'b1
`define MTC_SETTLE_FULL_RST 1'b1
`define MTC_MEAS_COUNT 4
`define MTC_STATE_WIDTH 32
`define MTC_FILE_DEPTH 100
`endif

// >>> mtc_pkg.sv
// Purpose: types for the measurement trigger control block
// Assumes: nothing
// Notes: one-hot cycle states
package mtc_pkg;
	typedef enum logic [3:0] {
		MTC_IDLE = 4'h1,
		MTC_SETTLE = 4'h2,
		MTC_MEASURE = 4'h4,
		MTC_HOLD = 4'h8
	} mtc_cycle_type;
endpackage

// >>> mtc_state_mem.sv
// Purpose: numbered instrument-state store
// Assumes: single port, synchronous write
// Notes: read data registered
`timescale 1ns/100ps
`include "mtc_regs.svh"
module mtc_state_mem #(
	parameter int WIDTH = `MTC_STATE_WIDTH,
	parameter int DEPTH = `MTC_FILE_DEPTH
) (
	// clock
	input wire logic clk_in,
	// access
	input wire logic wr_in,
	input wire logic [6:0] addr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	output logic [WIDTH-1:0] rdata_out
);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	always_ff @(posedge clk_in) begin
		if (wr_in) begin
			mem[addr_in] <= wdata_in;
		end
		rdata_out <= mem[addr_in];
	end
endmodule // mtc_state_mem

// >>> mtc_meas_model.sv
// Purpose: stand-in for the measurement engines behind the trigger block
// Assumes: one start pulse begins one attempt of LAT cycles
// Notes: valid toggles outside done so a stale level is never trusted
`timescale 1ns/100ps
module mtc_meas_model #(
	parameter int MEAS = 4,
	parameter int LAT = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic [MEAS-1:0] start_in,
	input wire logic [MEAS-1:0] bad_in,
	// results
	output logic [MEAS-1:0] done_out,
	output logic [MEAS-1:0] valid_out
);
	int cnt [MEAS];
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_out <= '0;
			valid_out <= '0;
			for (int i = 0; i < MEAS; i++) cnt[i] <= 0;
		end else begin
			for (int i = 0; i < MEAS; i++) begin
				done_out[i] <= cnt[i] == 1;
				valid_out[i] <= (cnt[i] == 1) ? !bad_in[i] : !valid_out[i];
				if (start_in[i]) cnt[i] <= LAT;
				else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
			end
		end
	end
endmodule // mtc_meas_model

// >>> tb.sv
// Purpose: self-checking bench for the trigger control block
// Assumes: settle count shortened to 3 cycles
// Notes: bench plays the bus controller, the model plays the engines
`timescale 1ns/100ps
module tb;
	localparam int SC = 3;
	localparam logic [3:0] ACT = 4'h3;
	logic clk, rst_n, get, trg, imm, abort, set_rt, rt_rep, set_st, st_full, preset;
	logic go_local, c_rst, go_remote, query, save, recall, common_cmd;
	logic holdoff, rep, full, rv, reject, ack;
	logic [3:0] on_scr, st_on, done, valid, bad, arm, start, held;
	logic [7:0] fnum;
	logic [31:0] st_in, restore;
	int fails, tests_run;
	mtc_trigger_ctrl #(.MEAS(4), .SW(32), .SETTLE_CYCLES(SC)) u_dut (.CLK_SYS_IN(clk),
		.RST_N_IN(rst_n), .GET_IN(get), .TRG_CMD_IN(trg), .IMMEDIATE_TRIGGER_CMD_IN(imm),
		.ABORT_IN(abort), .SET_RETRIG_IN(set_rt), .RETRIG_REP_IN(rt_rep), .SET_SETTLE_IN(set_st),
		.SETTLE_FULL_IN(st_full), .PRESET_IN(preset), .GO_LOCAL_IN(go_local),
		.COMMON_RESET_IN(c_rst), .GO_REMOTE_IN(go_remote), .ON_SCREEN_IN(on_scr),
		.STATE_ON_IN(st_on), .MEAS_DONE_IN(done), .MEAS_VALID_IN(valid), .QUERY_IN(query),
		.SAVE_IN(save), .RECALL_IN(recall), .FILE_NUM_IN(fnum), .STATE_IN(st_in),
		.COMMON_CMD_IN(common_cmd), .ARM_OUT(arm), .START_OUT(start), .HELD_OUT(held),
		.HOLDOFF_OUT(holdoff), .RETRIG_REP_OUT(rep), .SETTLE_FULL_OUT(full),
		.RESTORE_STATE_OUT(restore), .RESTORE_VALID_OUT(rv), .FILE_REJECT_OUT(reject),
		.COMMON_ACK_OUT(ack));
	mtc_meas_model #(.MEAS(4), .LAT(4)) u_meas (.clk_in(clk), .rst_n_in(rst_n),
		.start_in(start), .bad_in(bad), .done_out(done), .valid_out(valid));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask
	task automatic mode(input logic r, input logic f);
		rt_rep = r;
		st_full = f;
		pulse(set_rt);
		pulse(set_st);
	endtask
	task automatic wait_held;
		int n;
		n = 0;
		while (held !== ACT && n < 40) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic t_defaults;
		chk("rep after reset", 1, rep);
		chk("full after reset", 1, full);
		for (int i = 0; i < 3; i++) begin
			mode(0, 0);
			chk("rep set", 0, rep);
			chk("full set", 0, full);
			case (i)
				0: pulse(preset);
				1: pulse(go_local);
				default: pulse(c_rst);
			endcase
			chk("rep default", 1, rep);
			chk("full default", 1, full);
		end
		mode(0, 0);
		pulse(go_remote);
		chk("remote keeps mode", 0, rep);
	endtask
	task automatic t_sources;
		for (int i = 0; i < 3; i++) begin
			// controller lets transients die down first in fast mode
			repeat (2) @(negedge clk);
			case (i)
				0: pulse(get);
				1: pulse(trg);
				default: pulse(imm);
			endcase
			chk("start", ACT, start);
			chk("arm", ACT, arm);
			wait_held();
			chk("held", ACT, held);
			chk("disarmed", 0, arm);
			repeat (8) @(negedge clk);
			chk("no restart", 0, start);
			chk("held kept", ACT, held);
		end
	endtask
	task automatic t_retry;
		int n;
		n = 0;
		bad = 4'h1;
		pulse(imm);
		repeat (15) begin
			@(negedge clk);
			if (start[0] === 1'b1) n++;
		end
		chk("retries", 1, n >= 2);
		pulse(query);
		chk("holdoff", 1, holdoff);
		bad = 4'h0;
		wait_held();
		chk("held after retry", ACT, held);
		bad = 4'h1;
		pulse(imm);
		repeat (12) @(negedge clk);
		pulse(query);
		chk("holdoff retry", 1, holdoff);
		pulse(abort);
		chk("abort arm", 0, arm);
		chk("abort holdoff", 0, holdoff);
		bad = 4'h0;
	endtask
	task automatic t_repeat;
		int n;
		n = 0;
		mode(1, 0);
		pulse(imm);
		repeat (20) begin
			@(negedge clk);
			if (start === ACT) n++;
		end
		chk("restarts", 1, n >= 2);
		chk("rearmed", ACT, arm);
		pulse(abort);
	endtask
	task automatic t_settle;
		int n;
		mode(0, 1);
		pulse(trg);
		chk("settle gap", 0, start);
		// a trigger while settling is refused and must not stretch the delay
		pulse(imm);
		n = 3;
		while (start !== ACT && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("settle cycles", SC + 1, n);
		pulse(abort);
	endtask
	task automatic t_files;
		for (int i = 0; i < 4; i++) begin
			fnum = i[0] ? 8'h63 : 8'h00;
			st_in = i[0] ? 32'hA5C3_0F99 : 32'h1234_5678;
			if (i < 2) pulse(save);
			else begin
				pulse(recall);
				@(negedge clk);
				chk("recall valid", 1, rv);
				chk("recall data", st_in, restore);
			end
		end
		fnum = 8'h64;
		pulse(save);
		chk("save reject", 1, reject);
		pulse(recall);
		chk("recall reject", 1, reject);
		@(negedge clk);
		chk("no restore", 0, rv);
		pulse(common_cmd);
		chk("common ack", 1, ack);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{get, trg, imm, abort, set_rt, rt_rep, set_st, st_full, preset, go_local} = '0;
		{c_rst, go_remote, query, save, recall, common_cmd} = '0;
		on_scr = 4'hB;
		st_on = 4'h7;
		bad = 4'h0;
		fnum = 8'h00;
		st_in = 32'h0;
		fails = 0;
		tests_run = 0;
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		t_defaults();
		t_sources();
		t_retry();
		t_repeat();
		t_settle();
		t_files();
		stop_test();
	end
	// the whole run needs well under 1000 cycles
	initial begin
		#20us;
		fails++;
		stop_test();
	end
endmodule // tb
